// ---- rtl/ppoc_map.vh ----
`ifndef PPOC_MAP_VH
`define PPOC_MAP_VH

// Register indices; the byte address is four times the index.
`define PPOC_LOCK_IDX    14'h30E1
`define PPOC_WIDTH_IDX   14'h30EA
`define PPOC_WINDOW_IDX  14'h30EB
`define PPOC_MODE_IDX    14'h3100
`define PPOC_POWER_IDX   14'h3101
`define PPOC_STATUS_IDX  14'h3102
`define PPOC_MASK_IDX    14'h3103
`define PPOC_LEVEL_IDX   14'h3104

// Reset values.
`define PPOC_LOCK_RST    8'h0A
`define PPOC_WIDTH_RST   4'h5
`define PPOC_WINDOW_RST  8'h14
`define PPOC_MODE_RST    1'b0

// Field position of the ganged-mode bit in the mode register.
`define PPOC_MODE_GANG   0

// AXI responses.
`define PPOC_RESP_OKAY   2'h0
`define PPOC_RESP_SLVERR 2'h2

// Timebase: one millisecond tick at the system clock rate.
`define PPOC_TICK_US     1000
`define PPOC_CLK_MHZ     25
`define PPOC_TICK_CYC    (`PPOC_TICK_US * `PPOC_CLK_MHZ)

`endif

// ---- rtl/ppoc_ctl.v ----
// Notes on behaviour
// [R01] Individual per-port mode is the reset default.
// [R02] One combined power and sense pin per port.
// [R03] Power off: drive pin low, pull-up off.
// [R04] Power on: release driver, enable pull-up.
// [R05] Low pin level means overcurrent.
// [R06] Filter sense input against brief transients.
// [R07] Sample pin continuously while port enabled.
// [R08] Long continuous low flags overcurrent.
// [R09] Two low groups within window flag overcurrent.
// [R10] Ignore pin during lockout after power-on.
// [R11] Minimum width field bits 3:0, default 5.
// [R12] Double window eight bits, default 20 ms.
// [R13] Lockout eight bits, default 10 ms.
// [R14] Software never writes zero window or lockout.
// [R15] Poly-fuse wiring uses identical scheme and detection.
// [R16] Poly-fuse needs zero power-good descriptor delay.
// [R17] Charge enable strap set for intended ports.
// [R18] Ganged: shared pin, overcurrent flags all ports.
// [R19] Derive one millisecond tick from clock.
`include "ppoc_map.vh"
`default_nettype none

module ppoc_ctl #(
    parameter NPORTS      = 6,
    parameter TICK_CYCLES = `PPOC_TICK_CYC
) (
    // Clock and reset.
    input  wire              CLOCK,
    input  wire              RSTN,
    // AXI4-Lite write address channel.
    input  wire [15:0]       S_AXI_AWADDR,
    input  wire [2:0]        S_AXI_AWPROT,
    input  wire              S_AXI_AWVALID,
    output wire              S_AXI_AWREADY,
    // AXI4-Lite write data channel.
    input  wire [31:0]       S_AXI_WDATA,
    input  wire [3:0]        S_AXI_WSTRB,
    input  wire              S_AXI_WVALID,
    output wire              S_AXI_WREADY,
    // AXI4-Lite write response channel.
    output wire [1:0]        S_AXI_BRESP,
    output wire              S_AXI_BVALID,
    input  wire              S_AXI_BREADY,
    // AXI4-Lite read address channel.
    input  wire [15:0]       S_AXI_ARADDR,
    input  wire [2:0]        S_AXI_ARPROT,
    input  wire              S_AXI_ARVALID,
    output wire              S_AXI_ARREADY,
    // AXI4-Lite read data channel.
    output wire [31:0]       S_AXI_RDATA,
    output wire [1:0]        S_AXI_RRESP,
    output wire              S_AXI_RVALID,
    input  wire              S_AXI_RREADY,
    // Per-port combined power and sense pins.
    input  wire [NPORTS-1:0] PORT_POWER_SENSE_PIN_I,
    output wire [NPORTS-1:0] PORT_POWER_SENSE_PIN_O,
    output wire [NPORTS-1:0] PORT_POWER_SENSE_PIN_OE_N,
    output wire [NPORTS-1:0] PORT_PULLUP_EN,
    // Shared pin used in ganged mode.
    input  wire              SHARED_POWER_PIN_I,
    output wire              SHARED_POWER_PIN_O,
    output wire              SHARED_POWER_PIN_OE_N,
    output wire              SHARED_PULLUP_EN,
    // Interrupt.
    output wire              IRQ
);

    // The last count is worked out at full width and then cut to the 16-bit counter.
    localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
    localparam [15:0] TICK_LAST   = TICK_LAST_W[15:0];

    // Configuration and status registers.
    reg [7:0]        lock_reg;     // Lockout time in ms.
    reg [3:0]        width_reg;    // Minimum single-pulse width in ms.
    reg [7:0]        window_reg;   // Double-pulse window in ms.
    reg              gang_reg;     // Ganged mode when set.
    reg [NPORTS-1:0] power_reg;    // Per-port power request.
    reg [NPORTS-1:0] status_reg;   // Sticky overcurrent flags.
    reg [NPORTS-1:0] mask_reg;     // Interrupt enables.
    reg [NPORTS-1:0] status_next;  // Next status value.

    // Bus slave state.
    reg              aw_full_reg;  // Write address held.
    reg [15:0]       aw_addr_reg;  // Held write address.
    reg              w_full_reg;   // Write data held.
    reg [31:0]       w_data_reg;   // Held write data.
    reg [3:0]        w_strb_reg;   // Held byte enables.
    reg              bvalid_reg;   // Write response pending.
    reg [1:0]        bresp_reg;    // Write response code.
    reg              rvalid_reg;   // Read data pending.
    reg [31:0]       rdata_reg;    // Read data.
    reg [1:0]        rresp_reg;    // Read response code.
    reg [31:0]       rd_mux;       // Decoded read value.
    reg              rd_err;       // Read address unmapped.
    reg              wr_err;       // Write address unmapped.

    // Millisecond timebase.
    reg [15:0]       tick_cnt_reg; // Cycle count within a tick.
    wire             tick;         // One-cycle pulse each ms.
    wire [NPORTS-1:0] ev;          // Per-port detection pulses.
    wire [NPORTS-1:0] oc_vec;      // Events after ganged fan-out.

    wire do_wr  = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire do_rd  = S_AXI_ARVALID & ~rvalid_reg;
    wire rd_clr = do_rd & (S_AXI_ARADDR[15:2] == `PPOC_STATUS_IDX);

    // Handshakes are combinational; responses come from flip-flops.
    assign S_AXI_AWREADY = ~aw_full_reg;
    assign S_AXI_WREADY  = ~w_full_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_ARREADY = ~rvalid_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;

    // The tick free-runs so every timer shares one phase.
    assign tick = (tick_cnt_reg == TICK_LAST); // [R19]

    // Tick counter.
    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            tick_cnt_reg <= 16'h0000;
        else if (tick)
            tick_cnt_reg <= 16'h0000; // [R19]
        else
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end

    // Pin drive: low and unpulled when off, released with pull-up when on.
    // In ganged mode the per-port pins stay driven low and the shared pin
    // takes over, so no port is left floating.
    assign PORT_POWER_SENSE_PIN_O    = {NPORTS{1'b0}}; // [R02] [R03]
    assign PORT_POWER_SENSE_PIN_OE_N = power_reg & {NPORTS{~gang_reg}}; // [R03] [R04]
    assign PORT_PULLUP_EN            = power_reg & {NPORTS{~gang_reg}}; // [R04] [R15]
    assign SHARED_POWER_PIN_O        = 1'b0;
    assign SHARED_POWER_PIN_OE_N     = gang_reg & power_reg[0]; // [R18]
    assign SHARED_PULLUP_EN          = gang_reg & power_reg[0]; // [R18]

    // Per-port detector: lockout, single-pulse and double-pulse timers.
    genvar g;
    generate
        for (g = 0; g < NPORTS; g = g + 1)
        begin : port
            reg [7:0] lock_cnt_reg; // Remaining lockout ms.
            reg [3:0] low_cnt_reg;  // Ms spent low, saturating.
            reg [7:0] win_cnt_reg;  // Remaining window ms.
            reg       pwr_d_reg;    // Power state one cycle back.
            reg       prev_hi_reg;  // Previous sample was high.
            wire pwr  = gang_reg ? power_reg[0] : power_reg[g];
            wire pin  = gang_reg ? SHARED_POWER_PIN_I : PORT_POWER_SENSE_PIN_I[g];
            wire rise = pwr & ~pwr_d_reg;
            // Sampling only counts once power is settled and unlocked.
            wire live = pwr & pwr_d_reg & (lock_cnt_reg == 8'h00); // [R07] [R10]
            wire low  = live & ~pin; // [R05] [R15]
            wire fall = low & prev_hi_reg;

            // A low counts only once it lasts the width; a zero width
            // passes the first low sample straight through.
            assign ev[g] = (low & (low_cnt_reg >= width_reg)) | // [R06] [R08]
                           (fall & (win_cnt_reg != 8'h00));     // [R09]

            // Timer updates.
            always @(posedge CLOCK or negedge RSTN)
            begin
                if (!RSTN)
                begin
                    lock_cnt_reg <= 8'h00;
                    low_cnt_reg  <= 4'h0;
                    win_cnt_reg  <= 8'h00;
                    pwr_d_reg    <= 1'b0;
                    prev_hi_reg  <= 1'b1;
                end
                else
                begin
                    pwr_d_reg   <= pwr;
                    prev_hi_reg <= ~low;
                    // A zero lockout would give no masking at all.
                    if (rise)
                        lock_cnt_reg <= lock_reg; // [R10] [R14]
                    else if (!pwr)
                        lock_cnt_reg <= 8'h00;
                    else if (tick && (lock_cnt_reg != 8'h00))
                        lock_cnt_reg <= lock_cnt_reg - 8'h01; // [R10]
                    // Single-pulse width grows only while low.
                    if (!low)
                        low_cnt_reg <= 4'h0; // [R08]
                    else if (tick && (low_cnt_reg != 4'hF))
                        low_cnt_reg <= low_cnt_reg + 4'h1; // [R08]
                    // First group opens the window, a second inside hits.
                    if (!live)
                        win_cnt_reg <= 8'h00;
                    else if (fall && (win_cnt_reg == 8'h00))
                        win_cnt_reg <= window_reg; // [R09] [R14]
                    else if (fall)
                        win_cnt_reg <= 8'h00;
                    else if (tick && (win_cnt_reg != 8'h00))
                        win_cnt_reg <= win_cnt_reg - 8'h01; // [R09]
                end
            end
        end
    endgenerate

    // Ganged mode spreads any event to every port.
    assign oc_vec = gang_reg ? {NPORTS{|ev}} : ev; // [R18]

    // A new event wins over a read-clear in the same cycle.
    always @*
    begin
        status_next = status_reg;
        if (rd_clr)
            status_next = {NPORTS{1'b0}};
        status_next = status_next | oc_vec;
    end

    assign IRQ = |(status_reg & mask_reg);

    // Write decode flags unmapped addresses.
    always @*
    begin
        case (aw_addr_reg[15:2])
            `PPOC_LOCK_IDX, `PPOC_WIDTH_IDX, `PPOC_WINDOW_IDX,
            `PPOC_MODE_IDX, `PPOC_POWER_IDX, `PPOC_STATUS_IDX,
            `PPOC_MASK_IDX, `PPOC_LEVEL_IDX:
                wr_err = 1'b0;
            default:
                wr_err = 1'b1;
        endcase
    end

    // Read multiplexer; unused upper bits read as zero.
    always @*
    begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (S_AXI_ARADDR[15:2])
            `PPOC_LOCK_IDX:   rd_mux[7:0] = lock_reg;
            `PPOC_WIDTH_IDX:  rd_mux[3:0] = width_reg; // [R11]
            `PPOC_WINDOW_IDX: rd_mux[7:0] = window_reg;
            `PPOC_MODE_IDX:   rd_mux[`PPOC_MODE_GANG] = gang_reg;
            `PPOC_POWER_IDX:  rd_mux[NPORTS-1:0] = power_reg;
            `PPOC_STATUS_IDX: rd_mux[NPORTS-1:0] = status_reg;
            `PPOC_MASK_IDX:   rd_mux[NPORTS-1:0] = mask_reg;
            `PPOC_LEVEL_IDX:  rd_mux[NPORTS-1:0] = PORT_POWER_SENSE_PIN_I;
            default:          rd_err = 1'b1;
        endcase
    end

    // Bus slave and register file.
    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 16'h0000;
            w_full_reg  <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `PPOC_RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= `PPOC_RESP_OKAY;
            lock_reg    <= `PPOC_LOCK_RST;   // [R13]
            width_reg   <= `PPOC_WIDTH_RST;  // [R11]
            window_reg  <= `PPOC_WINDOW_RST; // [R12]
            gang_reg    <= `PPOC_MODE_RST;   // [R01]
            power_reg   <= {NPORTS{1'b0}};
            status_reg  <= {NPORTS{1'b0}};
            mask_reg    <= {NPORTS{1'b0}};
        end
        else
        begin
            status_reg <= status_next;
            // Address and data are caught in either order.
            if (S_AXI_AWVALID && !aw_full_reg)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !w_full_reg)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (bvalid_reg && S_AXI_BREADY)
                bvalid_reg <= 1'b0;
            // All registers sit in byte lane 0.
            if (do_wr)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_err ? `PPOC_RESP_SLVERR : `PPOC_RESP_OKAY;
                if (w_strb_reg[0])
                begin
                    case (aw_addr_reg[15:2])
                        `PPOC_LOCK_IDX:   lock_reg   <= w_data_reg[7:0]; // [R13]
                        `PPOC_WIDTH_IDX:  width_reg  <= w_data_reg[3:0]; // [R11]
                        `PPOC_WINDOW_IDX: window_reg <= w_data_reg[7:0]; // [R12]
                        `PPOC_MODE_IDX:   gang_reg   <= w_data_reg[`PPOC_MODE_GANG];
                        `PPOC_POWER_IDX:  power_reg  <= w_data_reg[NPORTS-1:0];
                        `PPOC_MASK_IDX:   mask_reg   <= w_data_reg[NPORTS-1:0];
                        default:          mask_reg   <= mask_reg;
                    endcase
                end
            end
            // Read data is registered one cycle after the address.
            if (do_rd)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= rd_err ? `PPOC_RESP_SLVERR : `PPOC_RESP_OKAY;
            end
            else if (rvalid_reg && S_AXI_RREADY)
                rvalid_reg <= 1'b0;
        end
    end

endmodule // ppoc_ctl

`default_nettype wire

// ---- tb/ppoc_assertions.sv ----
`default_nettype none
// Watches bus handshakes and pin control outputs of the port controller.
module ppoc_chk #(parameter NPORTS = 6) (
    // Clock and reset.
    input wire logic              CLOCK,
    input wire logic              RSTN,
    // Bus handshakes.
    input wire logic              S_AXI_AWVALID,
    input wire logic              S_AXI_AWREADY,
    input wire logic              S_AXI_WVALID,
    input wire logic              S_AXI_WREADY,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic              S_AXI_RVALID,
    input wire logic              S_AXI_RREADY,
    // Pin control.
    input wire logic [NPORTS-1:0] PORT_POWER_SENSE_PIN_O,
    input wire logic [NPORTS-1:0] PORT_POWER_SENSE_PIN_OE_N,
    input wire logic [NPORTS-1:0] PORT_PULLUP_EN,
    input wire logic              SHARED_POWER_PIN_O,
    input wire logic              SHARED_POWER_PIN_OE_N,
    input wire logic              SHARED_PULLUP_EN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // Both write halves taken at one edge; a split write is not checked here.
    sequence s_wr_both;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    // An address taken with no answer pending.
    sequence s_rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    a_pin_never_high: assert property (PORT_POWER_SENSE_PIN_O == '0)
        else $error("port pin output drove high");
    a_shared_never_high: assert property (SHARED_POWER_PIN_O == 1'b0)
        else $error("shared pin output drove high");
    a_pullup_follows: assert property (PORT_PULLUP_EN == PORT_POWER_SENSE_PIN_OE_N)
        else $error("pull-up does not follow driver release");
    a_shared_pullup: assert property (SHARED_PULLUP_EN == SHARED_POWER_PIN_OE_N)
        else $error("shared pull-up does not follow shared driver");
    a_gang_ports_low: assert property (SHARED_POWER_PIN_OE_N |-> PORT_POWER_SENSE_PIN_OE_N == '0)
        else $error("port pin released while shared pin is live");
    // Both halves are held one cycle before the write fires, so the answer shows a cycle later.
    a_write_answer: assert property (s_wr_both |=> ##1 S_AXI_BVALID)
        else $error("write response late");
    a_bvalid_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    a_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer late or address still open");
    a_rvalid_clears: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read answer held after acceptance");
endmodule // ppoc_chk
bind ppoc_ctl ppoc_chk #(.NPORTS(NPORTS)) ppoc_chk_i (.*);
`default_nettype wire

// ---- tb/ppoc_switch_model.sv ----
`default_nettype none
// External power switch: pulls the pin low on a fault, pull-up lifts it otherwise.
module ppoc_switch_model #(parameter N = 6) (
    input  wire logic         clk,
    input  wire logic [N-1:0] oe_n,
    input  wire logic [N-1:0] pullup_en,
    input  wire logic [N-1:0] fault,
    output wire logic [N-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drift = 1'b0; // Toggles so a floating pin never settles to a lucky value.
    always @(posedge clk) drift <= ~drift;
    // The switch reports power good at once, as a zero power-good delay asks.
    // No charge strap is driven, so every port stays a plain port.
    // Device drive wins; a fault pulls the open-drain line low.
    assign pin = (oe_n & pullup_en & ~fault) | (oe_n & ~pullup_en & {N{drift}});
endmodule // ppoc_switch_model
`default_nettype wire

// ---- tb/tb.sv ----
`include "ppoc_map.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 10; // Short tick keeps millisecond counts cheap.
    localparam logic [15:0] A_LOCK = {`PPOC_LOCK_IDX, 2'b00};
    localparam logic [15:0] A_WID = {`PPOC_WIDTH_IDX, 2'b00};
    localparam logic [15:0] A_WIN = {`PPOC_WINDOW_IDX, 2'b00};
    localparam logic [15:0] A_MODE = {`PPOC_MODE_IDX, 2'b00};
    localparam logic [15:0] A_PWR = {`PPOC_POWER_IDX, 2'b00};
    localparam logic [15:0] A_STAT = {`PPOC_STATUS_IDX, 2'b00};
    localparam logic [15:0] A_MASK = {`PPOC_MASK_IDX, 2'b00};
    localparam logic [15:0] A_LEVEL = {`PPOC_LEVEL_IDX, 2'b00};
    typedef struct packed {
        logic [15:0] a;
        logic        wr;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0]  r;
    } ppoc_row_t;
    logic CLOCK = 1'b0, RSTN = 1'b0;
    logic [15:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [2:0] S_AXI_AWPROT = '0, S_AXI_ARPROT = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
    logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, IRQ, SHARED_POWER_PIN_I, SHARED_POWER_PIN_O;
    logic SHARED_POWER_PIN_OE_N, SHARED_PULLUP_EN;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
    logic [5:0] PORT_POWER_SENSE_PIN_I, PORT_POWER_SENSE_PIN_O;
    logic [5:0] PORT_POWER_SENSE_PIN_OE_N, PORT_PULLUP_EN;
    logic [6:0] flt = '0; // Fault requests: bits 5:0 per port, bit 6 shared pin.
    logic [31:0] rdat;
    int miscompares = 0;
    int compares = 0;
    ppoc_row_t rows [10];
    always #20 CLOCK = ~CLOCK;
    ppoc_ctl #(.NPORTS(6), .TICK_CYCLES(TICK)) ppoc_ctl_i (.*);
    ppoc_switch_model #(.N(6)) port_model_i (.clk(CLOCK), .oe_n(PORT_POWER_SENSE_PIN_OE_N),
        .pullup_en(PORT_PULLUP_EN), .fault(flt[5:0]), .pin(PORT_POWER_SENSE_PIN_I));
    ppoc_switch_model #(.N(1)) shared_model_i (.clk(CLOCK), .oe_n(SHARED_POWER_PIN_OE_N),
        .pullup_en(SHARED_PULLUP_EN), .fault(flt[6]), .pin(SHARED_POWER_PIN_I));
    // Counts a comparison and reports a difference at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Ready is sampled at the falling edge, where it is settled, and acted on at the rise.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, pb, ha, hw;
        @(posedge CLOCK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
        {pa, pw, pb} = 3'b111;
        while (pb)
        begin
            @(negedge CLOCK);
            ha = pa && S_AXI_AWREADY;
            hw = pw && S_AXI_WREADY;
            pb = !S_AXI_BVALID;
            r = S_AXI_BRESP;
            @(posedge CLOCK);
            pa = pa && !ha;
            pw = pw && !hw;
            {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {pa, pw, pb};
        end
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, pr, ha;
        @(posedge CLOCK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
        {pa, pr} = 2'b11;
        while (pr)
        begin
            @(negedge CLOCK);
            ha = pa && S_AXI_ARREADY;
            pr = !S_AXI_RVALID;
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            @(posedge CLOCK);
            pa = pa && !ha;
            {S_AXI_ARVALID, S_AXI_RREADY} <= {pa, pr};
        end
    endtask
    // Raises the chosen fault lines for n cycles, pulling their pins low.
    task automatic pulse(input int n, input logic [6:0] m);
        @(posedge CLOCK);
        flt <= m;
        repeat (n) @(posedge CLOCK);
        flt <= '0;
    endtask
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // The whole run needs about 500 cycles; a hang is cut well beyond that.
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        miscompares++;
        give_verdict();
    end
    initial
    begin
        rows[0] = '{A_LOCK, 1'b0, 32'h0, 32'h0A, 2'h0};
        rows[1] = '{A_WID, 1'b0, 32'h0, 32'h05, 2'h0};
        rows[2] = '{A_WIN, 1'b0, 32'h0, 32'h14, 2'h0};
        rows[3] = '{A_MODE, 1'b0, 32'h0, 32'h00, 2'h0};
        rows[4] = '{A_PWR, 1'b0, 32'h0, 32'h00, 2'h0};
        rows[5] = '{A_WID, 1'b1, 32'hF2, 32'h02, 2'h0};
        rows[6] = '{A_LOCK, 1'b1, 32'h03, 32'h03, 2'h0};
        rows[7] = '{A_WIN, 1'b1, 32'h04, 32'h04, 2'h0};
        rows[8] = '{A_MASK, 1'b1, 32'h3F, 32'h3F, 2'h0};
        rows[9] = '{16'h0000, 1'b1, 32'h05, 32'h00, 2'h2};
        repeat (3) @(posedge CLOCK);
        chk({IRQ, PORT_PULLUP_EN, PORT_POWER_SENSE_PIN_OE_N}, 32'h0);
        RSTN <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wr(rows[i].a, rows[i].d, rs);
            if (rows[i].wr)
                chk(rs, rows[i].r);
            rd(rows[i].a, rdat, rs);
            chk(rdat, rows[i].e);
            chk(rs, rows[i].r);
        end
        $display("register table test done");
        wr(A_PWR, 32'h01, rs);
        chk({PORT_POWER_SENSE_PIN_OE_N, PORT_PULLUP_EN}, 32'h041);
        rd(A_LEVEL, rdat, rs);
        chk(rdat, 32'h01);
        // Two pulses inside the lockout would hit the double-pulse check if it leaked.
        pulse(5, 7'h01);
        repeat (2) @(posedge CLOCK);
        pulse(5, 7'h01);
        repeat (40) @(posedge CLOCK);
        rd(A_STAT, rdat, rs);
        chk(rdat, 32'h0);
        pulse(5, 7'h01);
        repeat (60) @(posedge CLOCK);
        rd(A_STAT, rdat, rs);
        chk(rdat, 32'h0);
        pulse(30, 7'h01);
        repeat (2) @(posedge CLOCK);
        chk(IRQ, 32'h1);
        rd(A_STAT, rdat, rs);
        chk(rdat, 32'h1);
        rd(A_STAT, rdat, rs);
        chk(rdat, 32'h0);
        $display("single pulse and lockout test done");
        for (int m = 0; m < 2; m++)
        begin
            wr(A_MASK, m ? 32'h0 : 32'h3F, rs);
            repeat (60) @(posedge CLOCK);
            pulse(3, 7'h01);
            repeat (5) @(posedge CLOCK);
            pulse(3, 7'h01);
            repeat (3) @(posedge CLOCK);
            chk(IRQ, m ? 32'h0 : 32'h1);
            rd(A_STAT, rdat, rs);
            chk(rdat, 32'h1);
        end
        $display("double pulse and mask test done");
        wr(A_PWR, 32'h0, rs);
        chk({PORT_POWER_SENSE_PIN_OE_N, PORT_PULLUP_EN}, 32'h0);
        repeat (30) @(posedge CLOCK);
        rd(A_STAT, rdat, rs);
        chk(rdat, 32'h0);
        wr(A_MODE, 32'h1, rs);
        wr(A_PWR, 32'h1, rs);
        chk({SHARED_POWER_PIN_OE_N, SHARED_PULLUP_EN, PORT_POWER_SENSE_PIN_OE_N}, 32'hC0);
        repeat (40) @(posedge CLOCK);
        pulse(30, 7'h40);
        rd(A_STAT, rdat, rs);
        chk(rdat, 32'h3F);
        $display("ganged test done");
        @(posedge CLOCK);
        RSTN <= 1'b0;
        repeat (3) @(posedge CLOCK);
        chk({IRQ, SHARED_POWER_PIN_OE_N, PORT_POWER_SENSE_PIN_OE_N}, 32'h0);
        RSTN <= 1'b1;
        rd(A_MODE, rdat, rs);
        chk(rdat, 32'h0);
        rd(A_LOCK, rdat, rs);
        chk(rdat, 32'h0A);
        $display("reset test done");
        give_verdict();
    end
endmodule // tb
`default_nettype wire
